// *** sfseq_pkg.sv ***
package sfseq_pkg;

  // Command opcodes seen on the serial input
  localparam logic [7:0] OPC_WRITE_ENABLE_CMD_CMD  = 8'h06; // write_enable_cmd
  localparam logic [7:0] OPC_WRITE_DISABLE_CMD_CMD  = 8'h04; // write_disable_cmd
  localparam logic [7:0] OPC_STAT_CMD  = 8'h05; // status_read_cmd
  localparam logic [7:0] OPC_BSYON_CMD = 8'h70; // busy_output_on_cmd
  localparam logic [7:0] OPC_BSYOFF    = 8'h80; // busy_output_off_cmd
  localparam logic [7:0] OPC_AUTO_PGM  = 8'hAD; // auto_increment_program
  localparam logic [7:0] OPC_SECT_ERS  = 8'h20; // 4 KByte sector erase
  localparam logic [7:0] OPC_BLK32_ERS = 8'h52; // 32 KByte block erase
  localparam logic [7:0] OPC_BLK64_ERS = 8'hD8; // 64 KByte block erase
  localparam logic [7:0] OPC_CHIP_ERS  = 8'h60; // Chip erase
  localparam logic [7:0] OPC_CHIP_ERS2 = 8'hC7; // Chip erase, alternate

  // Array geometry
  localparam int          ADDR_W      = 24;
  localparam logic [23:0] TOP_ADDR    = 24'h03FFFF; // Highest array byte
  localparam logic [23:0] SECT_MASK   = 24'h000FFF; // 4 KByte span
  localparam logic [23:0] BLK32_MASK  = 24'h007FFF; // 32 KByte span
  localparam logic [23:0] BLK64_MASK  = 24'h00FFFF; // 64 KByte span
  localparam logic [7:0]  ERASED_BYTE = 8'hFF;

  // Frame lengths in bytes, opcode included
  localparam logic [2:0] LEN_SHORT  = 3'h1;
  localparam logic [2:0] LEN_ADDR   = 3'h4;
  localparam logic [2:0] LEN_AUTO_1 = 3'h6;
  localparam logic [2:0] LEN_AUTO_N = 3'h3;

  // Timing, clock 250 MHz
  localparam int CLK_PERIOD_PS       = 4000;
  localparam int PROG_TIME_NS        = 10000;    // byte_program_time, max
  localparam int SECT_ERASE_TIME_US  = 25000;    // sector_erase_time, max
  localparam int BLK_ERASE_TIME_US   = 25000;    // block_erase_time, max
  localparam int CHIP_ERASE_TIME_US  = 50000;    // chip erase time, max
  // Longest times round down
  localparam int PROG_CYC  = (PROG_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int SECT_CYC  = (SECT_ERASE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int BLK_CYC   = (BLK_ERASE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int CHIP_CYC  = (CHIP_ERASE_TIME_US * 1000) / (CLK_PERIOD_PS / 1000);
  localparam int TMR_W     = 26;

  localparam int FIFO_DEPTH = 8;

  // Array operation kinds
  typedef enum logic [2:0] {
    SFS_OP_PROG,
    SFS_OP_SECT,
    SFS_OP_BLK32,
    SFS_OP_BLK64,
    SFS_OP_CHIP
  } sfseq_kind_e;

  // One request to the flash array
  typedef struct packed {
    sfseq_kind_e kind;
    logic [23:0] addr;
    logic [7:0]  data;
  } sfseq_op_s;

  localparam sfseq_op_s OP_IDLE = '{kind: SFS_OP_PROG, addr: 24'h000000, data: 8'hFF};

  // Self-timer state
  typedef enum logic {SFS_T_IDLE, SFS_T_RUN} sfseq_tmr_e;

endpackage

// *** sfseq_sync.sv ***
`timescale 1ns/1ps
module sfseq_sync #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_reg;  // First stage, read only by second stage
  logic [W-1:0] sync_reg;  // Second stage

  // Two flops per bit; reset to idle high (deselected, clock high)
  genvar g;
  generate
    for (g = 0; g < W; g++) begin : g_bit
      always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
          meta_reg[g] <= 1'b1;
          sync_reg[g] <= 1'b1;
        end else begin
          meta_reg[g] <= d_i[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign q_o = sync_reg;

endmodule

// *** sfseq_fifo.sv ***
`timescale 1ns/1ps
module sfseq_fifo
  import sfseq_pkg::*;
#(
  parameter int W     = $bits(sfseq_op_s),
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Fill side
  input  wire logic         in_valid_i,
  output logic              in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  // Drain side
  output logic              out_valid_o,
  input  wire logic         out_ready_i,
  output logic      [W-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem_reg [DEPTH];  // Flip-flop storage
  logic [AW:0]  wp_reg, wp_next;  // Extra bit tells full from empty
  logic [AW:0]  rp_reg, rp_next;
  logic         push, pop;

  // Honest flags from pointer compare
  assign in_ready_o  = !((wp_reg[AW] != rp_reg[AW]) && (wp_reg[AW-1:0] == rp_reg[AW-1:0]));
  assign out_valid_o = (wp_reg != rp_reg);
  assign out_data_o  = mem_reg[rp_reg[AW-1:0]];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer advance
  always_comb begin
    wp_next = push ? (AW+1)'(wp_reg + 1'b1) : wp_reg;
    rp_next = pop ? (AW+1)'(rp_reg + 1'b1) : rp_reg;
  end

  // Pointer registers
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // Storage has no reset; nothing reads a slot before it is written
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wp_reg[AW-1:0]] <= in_data_i;
    end
  end

endmodule

// *** sfseq_top.sv ***
// Contract
// R1: Ignore auto-program start at protected address.
// R2: Host programs only erased ranges.
// R3: Polling mode accepts only ADH, 04H, 05H.
// R4: Capture ADH, address, two bytes, MSB first.
// R5: First byte even address, second odd.
// R6: Program starts at chip-select rise.
// R7: Follow-on pairs take next two addresses.
// R8: Host exits with 04H, then 80H.
// R9: No address wrap past top unprotected.
// R10: Host detects completion one of three ways.
// R11: 70H enables busy report on output.
// R12: Output shows busy while selected, else released.
// R13: Hardware mode accepts only ADH and 04H.
// R14: 04H clears write latch and auto mode.
// R15: 80H stops busy report on output.
// R16: 20H erases addressed 4 KByte sector.
// R17: Ignore protected sector or block erase.
// R18: 52H erases addressed 32 KByte block.
// R19: D8H erases addressed 64 KByte block.
// R20: 60H/C7H erase chip unless any protection.
// R21: Program and erase need write latch set.
// R22: Erases self-timed, busy until done.
// R23: Follow-on ADH carries data only.
// R24: 06H sets write latch.
// R25: Sample on rising clock; drop aborted frames.
// R26: Busy spans cycle; latch clears after single op.
`timescale 1ns/1ps
module sfseq_top
  import sfseq_pkg::*;
#(
  parameter int SECT_ERASE_CYC = SECT_CYC,
  parameter int BLK_ERASE_CYC  = BLK_CYC,
  parameter int CHIP_ERASE_CYC = CHIP_CYC
) (
  // Clock and reset
  input  wire logic        CLK_I,
  input  wire logic        RST_I,
  // Serial pins
  input  wire logic        CE_N_I,
  input  wire logic        SCK_I,
  input  wire logic        SI_I,
  output logic             SO_O,
  output logic             SO_OE_N_O,
  // Protection setting
  input  wire logic        PROT_EN_I,
  input  wire logic [23:0] PROT_BASE_I,
  // Array request stream
  output logic             OP_VALID_O,
  input  wire logic        OP_READY_I,
  output sfseq_op_s        OP_O,
  // Status bits
  output logic             BUSY_O,
  output logic             WEL_O,
  output logic             AAI_O,
  output logic             BSY_PIN_EN_O
);

  // Synchronised pins
  logic [2:0] pin_s;
  logic       ce_n_s, sck_s, si_s;
  logic       ce_d_reg, sck_d_reg;    // Delayed copies for edges
  logic       sck_rise, ce_rise, sel;

  // Serial shifter state
  logic [2:0]  bit_cnt_reg, bit_cnt_next;
  logic [2:0]  byte_cnt_reg, byte_cnt_next;
  logic [7:0]  sh_reg, sh_next;
  logic [7:0]  opc_reg, opc_next;
  logic [23:0] adr_reg, adr_next;
  logic [7:0]  d0_reg, d0_next;
  logic [7:0]  d1_reg, d1_next;
  logic [7:0]  byte_in;

  // Command and execution state
  logic        wel_reg, wel_next;     // write_enable_latch
  logic        aai_reg, aai_next;     // Auto-increment mode
  logic        hwd_reg, hwd_next;     // Busy report on output
  logic        clr_wel_reg, clr_wel_next;
  logic [23:0] ptr_reg, ptr_next;     // Current word address
  logic        busy_reg, busy_next;
  sfseq_tmr_e  tst_reg, tst_next;
  logic [TMR_W-1:0] tcnt_reg, tcnt_next;
  logic [1:0]  pend_n_reg, pend_n_next;
  sfseq_op_s   pend_a_reg, pend_a_next;
  sfseq_op_s   pend_b_reg, pend_b_next;

  // Combinational helpers
  logic        frame_ok, accept, launch;
  logic [2:0]  need_len;
  logic [23:0] word_a, lo_a, hi_a;
  logic [TMR_W-1:0] load_cyc;
  logic        fifo_in_ready, fifo_out_valid;
  logic [$bits(sfseq_op_s)-1:0] fifo_out;

  // True when any byte of [lo,hi] falls in the protected top range
  function automatic logic prot_f(input logic [23:0] hi, input logic en,
                                  input logic [23:0] base);
    prot_f = en && (hi >= base);
  endfunction

  // Pins cross into the core clock; sampled clock only at 80 ns period
  sfseq_sync #(.W(3)) u_sync (
    .clk_i (CLK_I),
    .rst_i (RST_I),
    .d_i   ({CE_N_I, SCK_I, SI_I}),
    .q_o   (pin_s)
  );
  assign ce_n_s   = pin_s[2];
  assign sck_s    = pin_s[1];
  assign si_s     = pin_s[0];
  assign sel      = !ce_n_s;
  // R25 rising clock
  assign sck_rise = sel && sck_s && !sck_d_reg;
  // R6 deselect edge
  assign ce_rise  = ce_n_s && !ce_d_reg;
  assign byte_in  = {sh_reg[6:0], si_s};

  // Edge detector flops
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      ce_d_reg  <= 1'b1;
      sck_d_reg <= 1'b1;
    end else begin
      ce_d_reg  <= ce_n_s;
      sck_d_reg <= sck_s;
    end
  end

  // Shifter: bytes MSB first, sorted by position in frame
  always_comb begin
    bit_cnt_next  = bit_cnt_reg;
    byte_cnt_next = byte_cnt_reg;
    sh_next       = sh_reg;
    opc_next      = opc_reg;
    adr_next      = adr_reg;
    d0_next       = d0_reg;
    d1_next       = d1_reg;
    if (!sel) begin
      // R25 deselect restarts
      bit_cnt_next  = 3'h0;
      byte_cnt_next = 3'h0;
    end else if (sck_rise) begin
      sh_next      = byte_in;
      bit_cnt_next = 3'(bit_cnt_reg + 3'h1);
      if (bit_cnt_reg == 3'h7) begin
        // Saturate so overlong frames stay invalid
        if (byte_cnt_reg != 3'h7) begin
          byte_cnt_next = 3'(byte_cnt_reg + 3'h1);
        end
        // R4 field order
        // R23 data only
        unique case (byte_cnt_reg)
          3'h0: opc_next = byte_in;
          3'h1: begin
            if (aai_reg) d0_next = byte_in;
            else adr_next[23:16] = byte_in;
          end
          3'h2: begin
            if (aai_reg) d1_next = byte_in;
            else adr_next[15:8] = byte_in;
          end
          3'h3: adr_next[7:0] = byte_in;
          3'h4: d0_next = byte_in;
          3'h5: d1_next = byte_in;
          default: ;
        endcase
      end
    end
  end

  // Shifter registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bit_cnt_reg  <= 3'h0;
      byte_cnt_reg <= 3'h0;
      sh_reg       <= 8'h00;
      opc_reg      <= 8'h00;
      adr_reg      <= 24'h000000;
      d0_reg       <= ERASED_BYTE;
      d1_reg       <= ERASED_BYTE;
    end else begin
      bit_cnt_reg  <= bit_cnt_next;
      byte_cnt_reg <= byte_cnt_next;
      sh_reg       <= sh_next;
      opc_reg      <= opc_next;
      adr_reg      <= adr_next;
      d0_reg       <= d0_next;
      d1_reg       <= d1_next;
    end
  end

  // Expected frame length for the captured opcode
  always_comb begin
    unique case (opc_reg)
      OPC_AUTO_PGM:                           need_len = aai_reg ? LEN_AUTO_N : LEN_AUTO_1;
      OPC_SECT_ERS, OPC_BLK32_ERS, OPC_BLK64_ERS: need_len = LEN_ADDR;
      default:                                need_len = LEN_SHORT;
    endcase
  end

  // R25 whole frames only
  assign frame_ok = ce_rise && (bit_cnt_reg == 3'h0) && (byte_cnt_reg == need_len);
  // R3 polling mode set
  // R13 hardware mode set
  assign accept = frame_ok && (!aai_reg || (opc_reg == OPC_AUTO_PGM) ||
                  (opc_reg == OPC_WRITE_DISABLE_CMD_CMD) || (!hwd_reg && opc_reg == OPC_STAT_CMD));
  assign word_a = {adr_reg[23:1], 1'b0};

  // Command decode, pending pushes and self-timer
  always_comb begin
    wel_next     = wel_reg;
    aai_next     = aai_reg;
    hwd_next     = hwd_reg;
    clr_wel_next = clr_wel_reg;
    ptr_next     = ptr_reg;
    tst_next     = tst_reg;
    tcnt_next    = tcnt_reg;
    pend_n_next  = pend_n_reg;
    pend_a_next  = pend_a_reg;
    pend_b_next  = pend_b_reg;
    launch       = 1'b0;
    load_cyc     = TMR_W'(PROG_CYC);
    lo_a         = adr_reg & TOP_ADDR;
    hi_a         = lo_a;
    // Drain held requests into the FIFO; a full FIFO stalls here
    if (pend_n_reg != 2'h0 && fifo_in_ready) begin
      pend_a_next = pend_b_reg;
      pend_n_next = 2'(pend_n_reg - 2'h1);
    end
    // Self-timer counts down the documented maximum
    if (tst_reg == SFS_T_RUN) begin
      tcnt_next = TMR_W'(tcnt_reg - 1'b1);
      if (tcnt_reg <= TMR_W'(1)) begin
        tst_next = SFS_T_IDLE;
      end
    end
    if (accept) begin
      unique case (opc_reg)
        // R24 set latch
        OPC_WRITE_ENABLE_CMD_CMD: if (!busy_reg) wel_next = 1'b1;
        // R14 clear both
        OPC_WRITE_DISABLE_CMD_CMD: begin
          wel_next = 1'b0;
          aai_next = 1'b0;
        end
        // R11 report on
        OPC_BSYON_CMD: if (!busy_reg) hwd_next = 1'b1;
        // R15 report off
        OPC_BSYOFF: if (!busy_reg) hwd_next = 1'b0;
        OPC_AUTO_PGM: begin
          // R7 next pair
          lo_a = aai_reg ? 24'(ptr_reg + 24'h000002) : (word_a & TOP_ADDR);
          hi_a = {lo_a[23:1], 1'b1};
          // R21 latch needed
          // R1 protected start
          // R9 no wrap
          if (wel_reg && !busy_reg && !prot_f(hi_a, PROT_EN_I, PROT_BASE_I) &&
              (!aai_reg || ptr_reg < TOP_ADDR - 24'h000001)) begin
            launch      = 1'b1;
            aai_next    = 1'b1;
            ptr_next    = lo_a;
            pend_n_next = 2'h2;
            // R5 even then odd
            pend_a_next = '{kind: SFS_OP_PROG, addr: lo_a, data: d0_reg};
            pend_b_next = '{kind: SFS_OP_PROG, addr: hi_a, data: d1_reg};
          end
        end
        OPC_SECT_ERS, OPC_BLK32_ERS, OPC_BLK64_ERS: begin
          // R16 sector span
          // R18 32 KByte span
          // R19 64 KByte span
          if (opc_reg == OPC_SECT_ERS) begin
            lo_a     = lo_a & ~SECT_MASK;
            hi_a     = lo_a | SECT_MASK;
            load_cyc = TMR_W'(SECT_ERASE_CYC);
          end else if (opc_reg == OPC_BLK32_ERS) begin
            lo_a     = lo_a & ~BLK32_MASK;
            hi_a     = lo_a | BLK32_MASK;
            load_cyc = TMR_W'(BLK_ERASE_CYC);
          end else begin
            lo_a     = lo_a & ~BLK64_MASK;
            hi_a     = lo_a | BLK64_MASK;
            load_cyc = TMR_W'(BLK_ERASE_CYC);
          end
          // R17 protected erase
          if (wel_reg && !busy_reg && !prot_f(hi_a, PROT_EN_I, PROT_BASE_I)) begin
            launch       = 1'b1;
            clr_wel_next = 1'b1;
            pend_n_next  = 2'h1;
            pend_a_next  = '{kind: (opc_reg == OPC_SECT_ERS) ? SFS_OP_SECT :
                             (opc_reg == OPC_BLK32_ERS) ? SFS_OP_BLK32 : SFS_OP_BLK64,
                             addr: lo_a, data: ERASED_BYTE};
          end
        end
        OPC_CHIP_ERS, OPC_CHIP_ERS2: begin
          load_cyc = TMR_W'(CHIP_ERASE_CYC);
          // R20 any protection
          if (wel_reg && !busy_reg && !PROT_EN_I) begin
            launch       = 1'b1;
            clr_wel_next = 1'b1;
            pend_n_next  = 2'h1;
            pend_a_next  = '{kind: SFS_OP_CHIP, addr: 24'h000000, data: ERASED_BYTE};
          end
        end
        // Status read and others: no action here
        default: ;
      endcase
    end
    // R22 self-timed start
    if (launch) begin
      tst_next  = SFS_T_RUN;
      tcnt_next = load_cyc;
    end
    // R26 busy spans timer and array hand-off
    busy_next = launch || (tst_next == SFS_T_RUN) || (pend_n_next != 2'h0) || fifo_out_valid;
    // R26 single op drops latch
    if (busy_reg && !busy_next && clr_wel_reg) begin
      wel_next     = 1'b0;
      clr_wel_next = 1'b0;
    end
  end

  // Command and execution registers
  always_ff @(posedge CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wel_reg     <= 1'b0;
      aai_reg     <= 1'b0;
      hwd_reg     <= 1'b0;
      clr_wel_reg <= 1'b0;
      ptr_reg     <= 24'h000000;
      busy_reg    <= 1'b0;
      tst_reg     <= SFS_T_IDLE;
      tcnt_reg    <= '0;
      pend_n_reg  <= 2'h0;
      pend_a_reg  <= OP_IDLE;
      pend_b_reg  <= OP_IDLE;
    end else begin
      wel_reg     <= wel_next;
      aai_reg     <= aai_next;
      hwd_reg     <= hwd_next;
      clr_wel_reg <= clr_wel_next;
      ptr_reg     <= ptr_next;
      busy_reg    <= busy_next;
      tst_reg     <= tst_next;
      tcnt_reg    <= tcnt_next;
      pend_n_reg  <= pend_n_next;
      pend_a_reg  <= pend_a_next;
      pend_b_reg  <= pend_b_next;
    end
  end

  // Array requests queue here; a slow array holds busy high
  sfseq_fifo #(.W($bits(sfseq_op_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_i       (CLK_I),
    .rst_i       (RST_I),
    .in_valid_i  (pend_n_reg != 2'h0),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (pend_a_reg),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (OP_READY_I),
    .out_data_o  (fifo_out)
  );
  assign OP_VALID_O = fifo_out_valid;
  assign OP_O       = sfseq_op_s'(fifo_out);

  // R12 busy on output pin; low means busy, released when deselected
  assign SO_OE_N_O = !(hwd_reg && aai_reg && sel);
  assign SO_O      = !busy_reg;

  // Status bits
  assign BUSY_O       = busy_reg;
  assign WEL_O        = wel_reg;
  assign AAI_O        = aai_reg;
  assign BSY_PIN_EN_O = hwd_reg;

endmodule

// *** sfseq_top_checker.sv ***
`timescale 1ns/1ps
module sfseq_top_checker
  import sfseq_pkg::*;
(
  // Clock and reset
  input wire logic        CLK_I,
  input wire logic        RST_I,
  // Serial pins
  input wire logic        CE_N_I,
  input wire logic        SO_O,
  input wire logic        SO_OE_N_O,
  // Protection setting
  input wire logic        PROT_EN_I,
  input wire logic [23:0] PROT_BASE_I,
  // Array stream
  input wire logic        OP_VALID_O,
  input wire logic        OP_READY_I,
  input wire sfseq_op_s   OP_O,
  // Status bits
  input wire logic        BUSY_O,
  input wire logic        WEL_O,
  input wire logic        AAI_O,
  input wire logic        BSY_PIN_EN_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (RST_I);

  a_oe_needs_mode: assert property (!SO_OE_N_O |-> BSY_PIN_EN_O && AAI_O)
    else $error("SO driven outside busy-report auto mode");
  a_oe_on_release: assert property (CE_N_I [*5] |-> SO_OE_N_O)
    else $error("SO still driven after deselect");
  a_so_shows_busy: assert property (!SO_OE_N_O && $stable(BUSY_O) |-> SO_O == !BUSY_O)
    else $error("SO level does not match busy");
  a_so_busy_req: assert property (!SO_OE_N_O && OP_VALID_O |-> !SO_O)
    else $error("SO shows ready with a request pending");
  a_aai_at_deselect: assert property ($changed(AAI_O) |-> $past(CE_N_I) && $past(CE_N_I, 2))
    else $error("Auto mode changed while selected");
  a_wel_at_deselect: assert property ($rose(WEL_O) |-> $past(CE_N_I) && $past(CE_N_I, 2))
    else $error("Write latch set while selected");
  a_busy_brings_op: assert property ($rose(BUSY_O) |-> ##[1:2] OP_VALID_O)
    else $error("Busy without array request");
  a_op_holds_busy: assert property (OP_VALID_O |-> BUSY_O)
    else $error("Pending request while not busy");
  a_stall_keeps_op: assert property (OP_VALID_O && !OP_READY_I |=> OP_VALID_O && $stable(OP_O))
    else $error("Request dropped or changed under stall");
  a_erase_needs_wel: assert property (OP_VALID_O && OP_O.kind != SFS_OP_PROG |-> WEL_O)
    else $error("Erase issued without write latch");
  a_prog_needs_aai: assert property (OP_VALID_O && OP_O.kind == SFS_OP_PROG |-> AAI_O)
    else $error("Program issued outside auto mode");
  a_chip_unprotected: assert property (OP_VALID_O && OP_O.kind == SFS_OP_CHIP |-> !PROT_EN_I)
    else $error("Chip erase under protection");
  a_prot_area_skip: assert property (OP_VALID_O && PROT_EN_I |-> OP_O.addr < PROT_BASE_I)
    else $error("Request into protected range");
endmodule

bind sfseq_top sfseq_top_checker u_chk (
  .CLK_I(CLK_I), .RST_I(RST_I), .CE_N_I(CE_N_I), .SO_O(SO_O), .SO_OE_N_O(SO_OE_N_O),
  .PROT_EN_I(PROT_EN_I), .PROT_BASE_I(PROT_BASE_I), .OP_VALID_O(OP_VALID_O),
  .OP_READY_I(OP_READY_I), .OP_O(OP_O), .BUSY_O(BUSY_O), .WEL_O(WEL_O), .AAI_O(AAI_O),
  .BSY_PIN_EN_O(BSY_PIN_EN_O)
);

// *** sfseq_host.sv ***
`timescale 1ns/1ps
module sfseq_host (
  // Core clock
  input  wire logic clk_i,
  // Serial pins
  output logic      ce_n_o,
  output logic      sck_o,
  output logic      si_o
);
  // Deselected, link clock parked low
  initial begin
    ce_n_o = 1'b1;
    sck_o  = 1'b0;
    si_o   = 1'b0;
  end

  // Wait whole core clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic send(input logic [47:0] d, input int nbits);
    ce_n_o <= 1'b0;
    for (int i = nbits - 1; i >= 0; i--) begin
      si_o <= d[i];
      tick(10);
      sck_o <= 1'b1;
      tick(10);
      sck_o <= 1'b0;
    end
    tick(10);
    ce_n_o <= 1'b1;
    // Released data line must not look held
    si_o   <= ~si_o;
    tick(8);
  endtask

  // select without clocks to read busy on SO
  task automatic hold(input int n);
    ce_n_o <= 1'b0;
    tick(n);
    ce_n_o <= 1'b1;
    tick(8);
  endtask
endmodule

// *** tb_sfseq_top.sv ***
`timescale 1ns/1ps
module tb_sfseq_top;
  import sfseq_pkg::*;
  // Short erase timers keep the run brief
  logic        clk, rst, ce_n, sck, si, so, so_oe_n;
  logic        prot_en, op_valid, op_ready, busy, write_enable_latch, auto_increment_program, bsy_en;
  logic [23:0] prot_base;
  sfseq_op_s   op;
  sfseq_op_s   got_q[$];
  int          err_count, check_count;
  logic [7:0]  ers_opc [5] = '{OPC_SECT_ERS, OPC_BLK32_ERS, OPC_BLK64_ERS, OPC_CHIP_ERS,
                                OPC_CHIP_ERS2};
  logic [23:0] ers_adr [5] = '{24'h02A000, 24'h028000, 24'h020000, 24'h000000, 24'h000000};
  sfseq_kind_e ers_knd [5] = '{SFS_OP_SECT, SFS_OP_BLK32, SFS_OP_BLK64, SFS_OP_CHIP,
                                SFS_OP_CHIP};
  localparam logic [34:0] M_ALL = 35'h7FFFFFFFF;
  localparam logic [34:0] M_ERS = 35'h7FFFFFF00;
  localparam logic [34:0] M_KND = 35'h700000000;

  // 250 MHz core clock
  initial clk = 1'b0;
  always #2 clk = ~clk;

  sfseq_host host (.clk_i(clk), .ce_n_o(ce_n), .sck_o(sck), .si_o(si));

  sfseq_top #(.SECT_ERASE_CYC(50), .BLK_ERASE_CYC(60), .CHIP_ERASE_CYC(80)) uut (
    .CLK_I(clk), .RST_I(rst), .CE_N_I(ce_n), .SCK_I(sck), .SI_I(si), .SO_O(so),
    .SO_OE_N_O(so_oe_n), .PROT_EN_I(prot_en), .PROT_BASE_I(prot_base),
    .OP_VALID_O(op_valid), .OP_READY_I(op_ready), .OP_O(op), .BUSY_O(busy),
    .WEL_O(write_enable_latch), .AAI_O(auto_increment_program), .BSY_PIN_EN_O(bsy_en)
  );

  // Array side: record every accepted request
  always @(posedge clk) begin
    if (op_valid === 1'b1 && op_ready === 1'b1) begin
      got_q.push_back(op);
    end
  end

  task automatic close_out;
    $display("Checks %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_bit(input string name, input logic exp, input logic got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %b seen %b", name, exp, got);
    end
  endtask

  // Compare next recorded request under a care mask
  task automatic chk_op(input string name, input logic [34:0] exp, input logic [34:0] m);
    logic [34:0] got;
    got = (got_q.size() > 0) ? got_q.pop_front() : 'x;
    check_count++;
    if ((got & m) !== (exp & m)) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp & m, got & m);
    end
  endtask

  // Bounded wait for an idle array side
  task automatic wait_idle;
    int n;
    for (n = 0; n < 6000 && (busy !== 1'b0 || op_valid !== 1'b0); n++) @(posedge clk);
    if (n == 6000) begin
      err_count++;
      $display("FAIL idle wait expected idle seen busy");
      close_out();
    end
  endtask

  initial begin
    rst = 1'b1;
    prot_en = 1'b0;
    prot_base = 24'h030000;
    op_ready = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    host.tick(6);
    chk_bit("busy", 1'b0, busy);
    chk_bit("so_oe_n", 1'b1, so_oe_n);
    host.send({OPC_SECT_ERS, 24'h001000}, 32);
    wait_idle();
    chk_bit("no request", 1'b1, got_q.size() == 0);
    // Every erase code, latch first
    for (int k = 0; k < 5; k++) begin
      host.send(OPC_WRITE_ENABLE_CMD_CMD, 8);
      chk_bit("wel", 1'b1, write_enable_latch);
      host.send(k < 3 ? {ers_opc[k], 24'h02ABCD} : 48'(ers_opc[k]), k < 3 ? 32 : 8);
      chk_bit("busy", 1'b1, busy);
      wait_idle();
      chk_bit("wel", 1'b0, write_enable_latch);
      chk_op("erase", {ers_knd[k], ers_adr[k], 8'h00}, k < 3 ? M_ERS : M_KND);
    end
    // Protected targets ignored
    prot_en <= 1'b1;
    // Lower base so both the erased sector and the word start sit inside it
    prot_base <= 24'h020000;
    host.send(OPC_WRITE_ENABLE_CMD_CMD, 8);
    host.send({OPC_SECT_ERS, 24'h031000}, 32);
    host.send(OPC_CHIP_ERS, 8);
    host.send({OPC_AUTO_PGM, 24'h030000, 16'h1234}, 48);
    wait_idle();
    chk_bit("no request", 1'b1, got_q.size() == 0);
    chk_bit("aai", 1'b0, auto_increment_program);
    prot_en <= 1'b0;
    // Auto program with busy report, array stalled
    host.send(OPC_BSYON_CMD, 8);
    chk_bit("busy pin mode", 1'b1, bsy_en);
    op_ready <= 1'b0;
    host.send({OPC_AUTO_PGM, 24'h000101, 8'hA5, 8'h3C}, 48);
    chk_bit("aai", 1'b1, auto_increment_program);
    fork
      host.hold(20);
      begin
        host.tick(12);
        chk_bit("so_oe_n", 1'b0, so_oe_n);
        chk_bit("so", 1'b0, so);
      end
    join
    chk_bit("so_oe_n", 1'b1, so_oe_n);
    host.send({OPC_SECT_ERS, 24'h001000}, 32);
    op_ready <= 1'b1;
    wait_idle();
    chk_op("word even", {SFS_OP_PROG, 24'h000100, 8'hA5}, M_ALL);
    chk_op("word odd", {SFS_OP_PROG, 24'h000101, 8'h3C}, M_ALL);
    chk_bit("no request", 1'b1, got_q.size() == 0);
    host.send({OPC_AUTO_PGM, 8'h11, 8'h22}, 24);
    wait_idle();
    chk_op("next even", {SFS_OP_PROG, 24'h000102, 8'h11}, M_ALL);
    chk_op("next odd", {SFS_OP_PROG, 24'h000103, 8'h22}, M_ALL);
    host.send(OPC_WRITE_DISABLE_CMD_CMD, 8);
    chk_bit("wel", 1'b0, write_enable_latch);
    chk_bit("aai", 1'b0, auto_increment_program);
    host.send(OPC_BSYOFF, 8);
    chk_bit("busy pin mode", 1'b0, bsy_en);
    // Polling mode: status read sent while busy, 70H refused even when idle
    host.send(OPC_WRITE_ENABLE_CMD_CMD, 8);
    host.send({OPC_AUTO_PGM, 24'h000200, 8'hC3, 8'hA5}, 48);
    host.send(OPC_STAT_CMD, 8);
    wait_idle();
    host.send(OPC_BSYON_CMD, 8);
    chk_bit("busy pin mode", 1'b0, bsy_en);
    chk_op("poll even", {SFS_OP_PROG, 24'h000200, 8'hC3}, M_ALL);
    chk_op("poll odd", {SFS_OP_PROG, 24'h000201, 8'hA5}, M_ALL);
    host.send(OPC_WRITE_DISABLE_CMD_CMD, 8);
    chk_bit("aai", 1'b0, auto_increment_program);
    host.send(OPC_WRITE_ENABLE_CMD_CMD, 5);
    chk_bit("wel", 1'b0, write_enable_latch);
    close_out();
  end
endmodule
